// ==== hw/cdp_charger_detect.sv ====
// Behaviour
// - detection disabled: both upstream data lines left undriven.
// - detection starts by itself on entering the charger detection stage.
// - data lines shorted reports dedicated charging port, code 001.
// - D+ reflected on D- reports charging downstream port 010, enhanced only.
// - 15k pull-downs on both lines report standard downstream port, 011.
// - result visible in serial registers and on the interrupt pin.
// - enhanced mode continues after a charger to tell DCP from CDP.
// - data contact detect ends after 199 to 204 ms; code ends it early once contact is seen.
// - voltage source and sink enabled 79 to 84 ms in primary step.
// - sequence ends 79 to 83 ms after data line voltage seen.
// - detection disabled: stage left 49 to 55 ms later.
// - charging port acknowledges charging query; others stay silent.
// - port charging role fixed after configuration.
// - charging logic drives power bit of charging-enabled ports.
// - after configuration charging ports powered until overcurrent or enumeration.
// - overcurrent on charging port removes power until full reset.
// - after enumeration hub logic owns power; host enables it.
// - port power feature 1: hub logic controls power bit.
// - port power feature 0: charging logic controls power bit of charging-enabled ports until enumeration.
// - overcurrent always negates power bit, whichever owner.
// - per-port charge enables at register D0, bit 1 is port 1.
`timescale 1ns/1ps
`include "cdp_map.svh"
module cdp_charger_detect #(
    parameter int NPORT       = 3,
    parameter int T_DCD       = `CDP_MS_CYC(`CDP_T_DCD_MIN_MS + 1),
    parameter int T_VDPSRC    = `CDP_MS_CYC(`CDP_T_VDPSRC_MIN_MS + 1),
    parameter int T_HICRNT    = `CDP_MS_CYC(`CDP_T_HICRNT_MIN_MS + 1),
    parameter int T_RELEASE   = `CDP_MS_CYC(`CDP_T_RELEASE_MIN_MS + 1)
) (
    input  wire logic                  clock_i,
    input  wire logic                  rstn_i,
    input  wire logic                  detect_stage_i,
    input  wire logic                  config_done_i,
    input  wire logic                  enumerated_i,
    input  wire logic                  dcd_contact_i,
    input  wire logic                  lines_shorted_i,
    input  wire logic                  vdm_reflect_i,
    input  wire logic                  pulldowns_i,
    input  wire logic                  reg_we_i,
    input  wire logic                  reg_re_i,
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [7:0]            reg_wdata_i,
    input  wire logic [NPORT:1]        port_power_feature_i,
    input  wire logic [NPORT:1]        hub_power_i,
    input  wire logic [NPORT:1]        overcurrent_sense_n_i,
    input  wire logic [NPORT:1]        charge_query_i,
    output logic      [7:0]            reg_rdata_o,
    output cdp_pkg::cdp_kind_t         charger_kind_code_o,
    output logic                       detect_done_o,
    output logic                       int_n_o,
    output logic                       dp_oe_o,
    output logic                       dm_oe_o,
    output logic                       vdat_src_en_o,
    output logic                       idat_sink_en_o,
    output logic      [NPORT:1]        port_power_bit_o,
    output logic      [NPORT:1]        charge_ack_o
);
    import cdp_pkg::*;

    logic       rst_meta_q;
    logic       rstn_q;
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_meta_q <= 1'b0;
            rstn_q     <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rstn_q     <= rst_meta_q;
        end
    end

    localparam int NS = 8 + 3 * NPORT;
    logic [NS-1:0] raw_in;
    logic [NS-1:0] syn;
    // overcurrent enters inverted: synchroniser reset then reads as no fault
    assign raw_in = {detect_stage_i, config_done_i, enumerated_i, dcd_contact_i,
                     lines_shorted_i, vdm_reflect_i, pulldowns_i, reg_we_i,
                     port_power_feature_i, ~overcurrent_sense_n_i, charge_query_i};

    cdp_sync #(
        .W (NS)
    ) u_sync (
        .clock_i (clock_i),
        .rstn_i  (rstn_q),
        .d_i     (raw_in),
        .q_o     (syn)
    );

    logic          stage_s;
    logic          cfg_s;
    logic          enum_s;
    logic          dcd_s;
    logic          short_s;
    logic          refl_s;
    logic          pd_s;
    logic          we_s;
    logic [NPORT:1] ppf_s;
    logic [NPORT:1] oc_s;
    logic [NPORT:1] query_s;
    assign {stage_s, cfg_s, enum_s, dcd_s, short_s, refl_s, pd_s, we_s,
            ppf_s, oc_s, query_s} = syn;

    // register file
    logic [7:0] charge_en_q;
    logic [1:0] ctrl_q;
    logic       cfg_lock_q;
    logic       we_prev_q;
    logic       we_pulse;
    assign we_pulse = we_s && !we_prev_q;

    always_ff @(posedge clock_i or negedge rstn_q)
    begin
        if (!rstn_q)
        begin
            charge_en_q <= `CDP_CHARGE_EN_RST;
            ctrl_q      <= 2'(`CDP_DETECT_CTRL_RST);
            cfg_lock_q  <= 1'b0;
            we_prev_q   <= 1'b0;
        end
        else
        begin
            we_prev_q <= we_s;
            if (cfg_s)
            begin
                cfg_lock_q <= 1'b1;
            end
            if (we_pulse && !cfg_lock_q)
            begin
                if (reg_addr_i == `CDP_OFS_CHARGE_EN)
                begin
                    charge_en_q <= reg_wdata_i;
                end
                if (reg_addr_i == `CDP_OFS_DETECT_CTRL)
                begin
                    ctrl_q <= reg_wdata_i[1:0];
                end
            end
        end
    end

    logic       det_en;
    logic       enh_en;
    assign det_en = ctrl_q[`CDP_CTRL_DET_EN_BIT];
    assign enh_en = ctrl_q[`CDP_CTRL_ENH_BIT];

    // detection sequencer
    cdp_state_t state_q;
    logic [31:0] tmr_q;
    cdp_kind_t  kind_q;
    logic       done_q;
    logic       stage_prev_q;
    logic       rd_clear;

    assign rd_clear = reg_re_i && (reg_addr_i == `CDP_OFS_DETECT_STAT);

    always_ff @(posedge clock_i or negedge rstn_q)
    begin
        if (!rstn_q)
        begin
            state_q      <= CDP_IDLE;
            tmr_q        <= 32'h0;
            kind_q       <= `CDP_KIND_NONE;
            done_q       <= 1'b0;
            stage_prev_q <= 1'b0;
        end
        else
        begin
            stage_prev_q <= stage_s;
            tmr_q        <= tmr_q + 32'h1;
            unique case (state_q)
                CDP_IDLE:
                begin
                    tmr_q <= 32'h0;
                    if (stage_s && !stage_prev_q)
                    begin
                        kind_q  <= `CDP_KIND_NONE;
                        state_q <= det_en ? CDP_DCD : CDP_RELEASE;
                    end
                end
                CDP_DCD:
                begin
                    if (dcd_s || tmr_q >= 32'(T_DCD - 1))
                    begin
                        tmr_q   <= 32'h0;
                        state_q <= CDP_PRIMARY;
                    end
                end
                CDP_PRIMARY:
                begin
                    if (tmr_q >= 32'(T_VDPSRC - 1))
                    begin
                        tmr_q <= 32'h0;
                        if (pd_s)
                        begin
                            kind_q  <= `CDP_KIND_SDP;
                            state_q <= CDP_DONE;
                        end
                        else if (refl_s && enh_en)
                        begin
                            state_q <= CDP_SECONDARY;
                        end
                        else if (short_s)
                        begin
                            kind_q  <= `CDP_KIND_DCP;
                            state_q <= CDP_DONE;
                        end
                        else
                        begin
                            state_q <= CDP_DONE;
                        end
                    end
                end
                CDP_SECONDARY:
                begin
                    if (tmr_q >= 32'(T_HICRNT - 1))
                    begin
                        kind_q  <= short_s ? `CDP_KIND_DCP : `CDP_KIND_CDP;
                        state_q <= CDP_DONE;
                    end
                end
                CDP_RELEASE:
                begin
                    if (tmr_q >= 32'(T_RELEASE - 1))
                    begin
                        state_q <= CDP_DONE;
                    end
                end
                CDP_DONE:
                begin
                    state_q <= CDP_IDLE;
                end
            endcase
            // set wins over read clear
            if (state_q == CDP_DONE)
            begin
                done_q <= 1'b1;
            end
            else if (rd_clear)
            begin
                done_q <= 1'b0;
            end
        end
    end

    // outputs
    logic [NPORT:1] pwr_q;
    logic [NPORT:1] oc_trip_q;
    logic [NPORT:1] ack_q;

    always_ff @(posedge clock_i or negedge rstn_q)
    begin
        if (!rstn_q)
        begin
            charger_kind_code_o <= `CDP_KIND_NONE;
            detect_done_o       <= 1'b0;
            int_n_o             <= 1'b1;
            dp_oe_o             <= 1'b0;
            dm_oe_o             <= 1'b0;
            vdat_src_en_o       <= 1'b0;
            idat_sink_en_o      <= 1'b0;
            reg_rdata_o         <= 8'h00;
        end
        else
        begin
            // kind appears in the same cycle as done
            charger_kind_code_o <= (state_q == CDP_DONE) ? charger_kind_code_o : kind_q;
            detect_done_o       <= done_q;
            int_n_o             <= !done_q;
            // lines only driven while detection is live
            dp_oe_o             <= det_en && (state_q == CDP_PRIMARY
                                              || state_q == CDP_SECONDARY);
            dm_oe_o             <= det_en && (state_q == CDP_DCD);
            vdat_src_en_o       <= state_q == CDP_PRIMARY;
            idat_sink_en_o      <= state_q == CDP_PRIMARY;
            unique case (reg_addr_i)
                `CDP_OFS_CHARGE_EN:   reg_rdata_o <= charge_en_q;
                `CDP_OFS_DETECT_STAT: reg_rdata_o <= {4'h0, done_q, kind_q};
                `CDP_OFS_DETECT_CTRL: reg_rdata_o <= {6'h00, ctrl_q};
                default:              reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // downstream port power per port
    genvar p;
    generate
        for (p = 1; p <= NPORT; p++)
        begin : g_port
            always_ff @(posedge clock_i or negedge rstn_q)
            begin
                if (!rstn_q)
                begin
                    pwr_q[p]     <= 1'b0;
                    oc_trip_q[p] <= 1'b0;
                    ack_q[p]     <= 1'b0;
                end
                else
                begin
                    if (oc_s[p])
                    begin
                        oc_trip_q[p] <= 1'b1;
                    end
                    ack_q[p] <= charge_en_q[p] && cfg_lock_q && query_s[p];
                    if (oc_s[p] || (oc_trip_q[p] && charge_en_q[p]))
                    begin
                        pwr_q[p] <= 1'b0;
                    end
                    else if (ppf_s[p] || enum_s || !charge_en_q[p])
                    begin
                        pwr_q[p] <= hub_power_i[p];
                    end
                    else
                    begin
                        pwr_q[p] <= cfg_lock_q;
                    end
                end
            end
        end
    endgenerate

    assign port_power_bit_o = pwr_q;
    assign charge_ack_o     = ack_q;
endmodule

// ==== hw/cdp_map.svh ====
`ifndef CDP_MAP_SVH
`define CDP_MAP_SVH

`define CDP_OFS_CHARGE_EN     8'hD0
`define CDP_OFS_DETECT_STAT   8'hD1
`define CDP_OFS_DETECT_CTRL   8'hD2
`define CDP_CHARGE_EN_RST     8'h00
`define CDP_DETECT_CTRL_RST   8'h03
`define CDP_CTRL_DET_EN_BIT   0
`define CDP_CTRL_ENH_BIT      1
`define CDP_STAT_DONE_BIT     3
`define CDP_KIND_NONE         3'h0
`define CDP_KIND_DCP          3'h1
`define CDP_KIND_CDP          3'h2
`define CDP_KIND_SDP          3'h3
`define CDP_CLK_KHZ           40000
`define CDP_T_DCD_MIN_MS      199
`define CDP_T_DCD_MAX_MS      204
`define CDP_T_VDPSRC_MIN_MS   79
`define CDP_T_VDPSRC_MAX_MS   84
`define CDP_T_HICRNT_MIN_MS   79
`define CDP_T_HICRNT_MAX_MS   83
`define CDP_T_RELEASE_MIN_MS  49
`define CDP_T_RELEASE_MAX_MS  55
`define CDP_MS_CYC(ms)        ((ms) * `CDP_CLK_KHZ)

`endif

// ==== hw/cdp_pkg.sv ====
package cdp_pkg;
    typedef enum logic [2:0] {
        CDP_IDLE,
        CDP_DCD,
        CDP_PRIMARY,
        CDP_SECONDARY,
        CDP_RELEASE,
        CDP_DONE
    } cdp_state_t;
    typedef logic [2:0] cdp_kind_t;
endpackage

// ==== hw/cdp_sync.sv ====
`timescale 1ns/1ps
module cdp_sync #(
    parameter int W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= '0;
            q_o    <= '0;
        end
        else
        begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

// ==== sim/cdp_charger_detect_assertions.sv ====
`timescale 1ns/1ps
module cdp_checker #(
    parameter int NPORT    = 3,
    parameter int T_DCD    = 20,
    parameter int T_VDPSRC = 20,
    parameter int T_HICRNT = 20
) (
    input wire logic               clock_i,
    input wire logic               rstn_i,
    input wire logic               enumerated_i,
    input wire logic [NPORT:1]     port_power_feature_i,
    input wire logic [NPORT:1]     hub_power_i,
    input wire logic [NPORT:1]     overcurrent_sense_n_i,
    input wire logic [NPORT:1]     charge_query_i,
    input wire cdp_pkg::cdp_kind_t charger_kind_code_o,
    input wire logic               detect_done_o,
    input wire logic               int_n_o,
    input wire logic               dm_oe_o,
    input wire logic               vdat_src_en_o,
    input wire logic               idat_sink_en_o,
    input wire logic [NPORT:1]     port_power_bit_o,
    input wire logic [NPORT:1]     charge_ack_o
);
    import cdp_pkg::*;
    logic [31:0]    src_q, dcd_q;
    logic [NPORT:1] oc1_q, oc2_q, oc3_q, q1_q, q2_q, q3_q;
    // run lengths of the voltage source enable and the D- drive enable
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            src_q <= '0;
            dcd_q <= '0;
        end
        else
        begin
            src_q <= vdat_src_en_o ? src_q + 32'h1 : '0;
            dcd_q <= dm_oe_o ? dcd_q + 32'h1 : '0;
        end
    end
    // recent history of overcurrent and query inputs
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            {oc1_q, oc2_q, oc3_q, q1_q, q2_q, q3_q} <= '0;
        end
        else
        begin
            {oc1_q, oc2_q, oc3_q} <= {~overcurrent_sense_n_i, oc1_q, oc2_q};
            {q1_q, q2_q, q3_q} <= {charge_query_i, q1_q, q2_q};
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    property p_int_done; int_n_o == !detect_done_o; endproperty
    a_int_done: assert property (p_int_done)
        else $error("interrupt not inverse of done");
    property p_src_pair; vdat_src_en_o == idat_sink_en_o; endproperty
    a_src_pair: assert property (p_src_pair)
        else $error("source and sink enables differ");
    property p_src_len; $fell(vdat_src_en_o) |->
        src_q >= T_VDPSRC - 1 && src_q <= T_VDPSRC + T_HICRNT + 4; endproperty
    a_src_len: assert property (p_src_len)
        else $error("source enable length wrong");
    property p_dcd_len; dcd_q <= T_DCD + 4; endproperty
    a_dcd_len: assert property (p_dcd_len)
        else $error("contact detect step too long");
    property p_kind_done; $changed(charger_kind_code_o) && charger_kind_code_o != 3'h0
        |-> detect_done_o; endproperty
    a_kind_done: assert property (p_kind_done)
        else $error("kind changed without done");
    property p_oc_off; |(oc1_q & ~overcurrent_sense_n_i) |-> (port_power_bit_o & oc1_q
        & oc2_q & oc3_q & ~overcurrent_sense_n_i) == '0; endproperty
    a_oc_off: assert property (p_oc_off)
        else $error("power kept during overcurrent");
    property p_ack_query; |charge_ack_o |->
        (charge_ack_o & ~(charge_query_i | q1_q | q2_q | q3_q)) == '0; endproperty
    a_ack_query: assert property (p_ack_query)
        else $error("acknowledge without query");
    property p_hub_off; enumerated_i && $past(enumerated_i, 4) && (&port_power_feature_i)
        && $stable(hub_power_i) |-> (port_power_bit_o & ~$past(hub_power_i)) == '0;
    endproperty
    a_hub_off: assert property (p_hub_off)
        else $error("power on against hub request");
endmodule
bind cdp_charger_detect cdp_checker #(.NPORT(NPORT), .T_DCD(T_DCD), .T_VDPSRC(T_VDPSRC),
    .T_HICRNT(T_HICRNT)) cdp_checker_i (.clock_i(clock_i), .rstn_i(rstn_i),
    .enumerated_i(enumerated_i), .port_power_feature_i(port_power_feature_i),
    .hub_power_i(hub_power_i), .overcurrent_sense_n_i(overcurrent_sense_n_i),
    .charge_query_i(charge_query_i), .charger_kind_code_o(charger_kind_code_o),
    .detect_done_o(detect_done_o), .int_n_o(int_n_o), .dm_oe_o(dm_oe_o),
    .vdat_src_en_o(vdat_src_en_o), .idat_sink_en_o(idat_sink_en_o),
    .port_power_bit_o(port_power_bit_o), .charge_ack_o(charge_ack_o));

// ==== sim/cdp_charger_model.sv ====
`timescale 1ns/1ps
// upstream port profile: 0 none, 1 dedicated, 2 charging host, 3 standard host
module cdp_charger_model (
    input  wire logic       clock_i,
    input  wire logic [1:0] mode_i,
    input  wire logic       slow_i,
    input  wire logic       dm_oe_i,
    input  wire logic       vdat_src_en_i,
    output logic            dcd_contact_o,
    output logic            lines_shorted_o,
    output logic            vdm_reflect_o,
    output logic            pulldowns_o
);
    // slow partner never makes contact, so the step must time out
    always_ff @(posedge clock_i)
    begin
        dcd_contact_o <= dm_oe_i && mode_i != 2'h0 && !slow_i;
        lines_shorted_o <= mode_i == 2'h1;
        vdm_reflect_o <= vdat_src_en_i && (mode_i == 2'h1 || mode_i == 2'h2);
        pulldowns_o <= mode_i == 2'h3;
    end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`include "cdp_map.svh"
`define CHECK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; $display( \
    "unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module testbench;
    import cdp_pkg::*;
    localparam int T = 20;
    logic       clock_i = 1'b0, rstn_i = 1'b0, stage = 1'b0, cfg = 1'b0, slow = 1'b0;
    logic       enum_en = 1'b0, we = 1'b0, re = 1'b0, bad;
    logic [1:0] mode = 2'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rd_val;
    logic [3:1] feat = 3'h0, hpwr = 3'h0, oc_n = 3'h7, query = 3'h0, pwr, ack;
    logic       done, int_n, dp_oe, dm_oe, vsrc, isnk, dcd, shrt, refl, pdn;
    cdp_kind_t  kind;
    int         n_fail = 0, checks = 0, cyc = 0;
    cdp_charger_detect #(.T_DCD(T), .T_VDPSRC(T), .T_HICRNT(T), .T_RELEASE(T))
    cdp_charger_detect_i (
        .clock_i(clock_i), .rstn_i(rstn_i), .detect_stage_i(stage), .config_done_i(cfg),
        .enumerated_i(enum_en), .dcd_contact_i(dcd), .lines_shorted_i(shrt),
        .vdm_reflect_i(refl), .pulldowns_i(pdn), .reg_we_i(we), .reg_re_i(re),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .port_power_feature_i(feat),
        .hub_power_i(hpwr), .overcurrent_sense_n_i(oc_n), .charge_query_i(query),
        .reg_rdata_o(rdata), .charger_kind_code_o(kind), .detect_done_o(done),
        .int_n_o(int_n), .dp_oe_o(dp_oe), .dm_oe_o(dm_oe), .vdat_src_en_o(vsrc),
        .idat_sink_en_o(isnk), .port_power_bit_o(pwr), .charge_ack_o(ack));
    cdp_charger_model cdp_charger_model_i (
        .clock_i(clock_i), .mode_i(mode), .slow_i(slow), .dm_oe_i(dm_oe),
        .vdat_src_en_i(vsrc), .dcd_contact_o(dcd), .lines_shorted_o(shrt),
        .vdm_reflect_o(refl), .pulldowns_o(pdn));
    always #12.5 clock_i = ~clock_i;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            finish_test();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // write strobe is synchronised, so it is held and then spaced out
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        we = 1'b1;
        tick(4);
        we = 1'b0;
        tick(4);
    endtask
    task automatic rd(input logic [7:0] a);
        addr = a;
        re = 1'b1;
        tick(1);
        rd_val = rdata;
        re = 1'b0;
        tick(1);
    endtask
    task automatic t_reset();
        `CHECK({kind, done, int_n, dp_oe, dm_oe, pwr}, {3'h0, 4'h4, 3'h0})
        rd(`CDP_OFS_CHARGE_EN);
        `CHECK(rd_val, `CDP_CHARGE_EN_RST)
        rd(`CDP_OFS_DETECT_CTRL);
        `CHECK(rd_val, `CDP_DETECT_CTRL_RST)
        $display("reset test done");
    endtask
    task automatic t_disabled();
        int n;
        wr(`CDP_OFS_DETECT_CTRL, 8'h02);
        mode = 2'h3;
        stage = 1'b1;
        bad = 1'b0;
        n = 0;
        repeat (3 * T)
        begin
            tick(1);
            bad = bad | dp_oe | dm_oe;
            if (done !== 1'b1)
                n++;
        end
        `CHECK(bad, 1'b0)
        `CHECK(n >= T && n <= T + 8, 1'b1)
        rd(`CDP_OFS_DETECT_STAT);
        `CHECK(rd_val, {4'h0, 1'b1, `CDP_KIND_NONE})
        stage = 1'b0;
        mode = 2'h0;
        tick(2 * T);
        $display("disabled test done");
    endtask
    task automatic t_config();
        wr(`CDP_OFS_DETECT_CTRL, 8'h03);
        wr(`CDP_OFS_CHARGE_EN, 8'h06);
        rd(`CDP_OFS_CHARGE_EN);
        `CHECK(rd_val, 8'h06)
        cfg = 1'b1;
        tick(6);
        `CHECK(pwr, 3'h3)
        wr(`CDP_OFS_CHARGE_EN, 8'h00);
        rd(`CDP_OFS_CHARGE_EN);
        `CHECK(rd_val, 8'h06)
        query = 3'h7;
        tick(5);
        `CHECK(ack, 3'h3)
        query = 3'h0;
        tick(4);
        $display("config test done");
    endtask
    task automatic detect(input logic [1:0] m, input logic s, input cdp_kind_t exp);
        int n;
        mode = m;
        slow = s;
        stage = 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 6 * T)
        begin
            tick(1);
            n++;
        end
        `CHECK(n >= 2 * T && n <= 3 * T + 12, 1'b1)
        `CHECK(kind, exp)
        `CHECK(int_n, 1'b0)
        rd(`CDP_OFS_DETECT_STAT);
        `CHECK(rd_val, {4'h0, 1'b1, exp})
        tick(3);
        `CHECK(int_n, 1'b1)
        stage = 1'b0;
        mode = 2'h0;
        slow = 1'b0;
        tick(4);
        $display("detect test done, kind %h", exp);
    endtask
    task automatic t_power();
        oc_n = 3'h6;
        tick(4);
        `CHECK(pwr, 3'h2)
        oc_n = 3'h7;
        tick(6);
        `CHECK(pwr, 3'h2)
        enum_en = 1'b1;
        feat = 3'h7;
        hpwr = 3'h6;
        tick(6);
        `CHECK(pwr, 3'h6)
        oc_n = 3'h3;
        tick(4);
        `CHECK(pwr, 3'h2)
        oc_n = 3'h7;
        tick(6);
        `CHECK(pwr, 3'h6)
        $display("power test done");
    endtask
    initial
    begin
        tick(5);
        rstn_i = 1'b1;
        tick(6);
        t_reset();
        t_disabled();
        wr(`CDP_OFS_DETECT_CTRL, 8'h01);
        detect(2'h1, 1'b1, `CDP_KIND_DCP);
        detect(2'h2, 1'b1, `CDP_KIND_NONE);
        t_config();
        detect(2'h2, 1'b0, `CDP_KIND_CDP);
        detect(2'h1, 1'b0, `CDP_KIND_DCP);
        detect(2'h3, 1'b1, `CDP_KIND_SDP);
        t_power();
        finish_test();
    end
endmodule
